// File: rtl/keypad_pkg.sv
// Shared constants for the keypad mask and key-code register slice
package keypad_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets on the serial register port
    localparam logic [7:0] OFS_CLEAR = 8'h08;
    localparam logic [7:0] OFS_MASK  = 8'h09;
    localparam logic [7:0] OFS_CODE0 = 8'h0b;
    localparam logic [7:0] OFS_CODE1 = 8'h0c;
    localparam logic [7:0] OFS_CODE2 = 8'h0d;
    localparam logic [7:0] OFS_CODE3 = 8'h0e;

    ////////////////////////////////////////////////////////////////////////////////
    // Mask register layout and reset value
    localparam int         MASK_WIDTH        = 4;
    localparam int         MASK_EVT_LOST_BIT = 3;
    localparam int         MASK_EVT_BIT      = 2;
    localparam int         MASK_KEY_LOST_BIT = 1;
    localparam int         MASK_SCAN_BIT     = 0;
    localparam logic [3:0] MASK_RESET        = 4'h3;

    // Clear register layout
    localparam int CLR_SCAN_BIT = 0;
    localparam int CLR_EVT_BIT  = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Key-code register layout and reset content
    localparam int         KEY_SLOTS    = 4;
    localparam logic [2:0] ROW_RESET    = 3'h7;
    localparam logic [3:0] COL_RESET    = 4'hf;
    localparam logic [7:0] CODE_NO_KEY  = 8'h7f;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;

    // Serial slave address, seven bits; value is arbitrary
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h44;

    // Serial slave states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_ADDR  = 4'b0001,
        ST_ACK_A = 4'b0010,
        ST_REG   = 4'b0011,
        ST_ACK_R = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_ACK_W = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK  = 4'b1000
    } bus_state_e;

endpackage

// File: rtl/sync2.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
module sync2 (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    // First stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// File: rtl/scan_xfer.sv
// Toggle handshake that carries scan reports from the scan clock to the system clock
`timescale 1ns/10ps
module scan_xfer #(
    parameter int W = 32
) (
    // Source side
    input  wire logic         src_clk,
    input  wire logic         rst,
    input  wire logic         src_valid,
    input  wire logic [W-1:0] src_data,
    // Destination side
    input  wire logic         dst_clk,
    output logic              dst_valid,
    output logic [W-1:0]      dst_data
);
    logic         req_t_r;
    logic         ack_t_r;
    logic         ack_s;
    logic         req_s;
    logic         req_d_r;
    logic         pend_r;
    logic [W-1:0] pend_d_r;
    logic [W-1:0] hold_r;
    logic         busy;

    ////////////////////////////////////////////////////////////////////////////////
    // Source: hold stays still while a request is in flight
    assign busy = req_t_r ^ ack_s;

    // One report may wait; a newer one replaces it since only the last scan matters
    always_ff @(posedge src_clk or posedge rst) begin
        if (rst) begin
            req_t_r  <= 1'b0;
            pend_r   <= 1'b0;
            pend_d_r <= '0;
            hold_r   <= '0;
        end else if (!busy && (src_valid || pend_r)) begin
            hold_r   <= src_valid ? src_data : pend_d_r;
            req_t_r  <= ~req_t_r;
            pend_r   <= 1'b0;
        end else if (src_valid) begin
            pend_r   <= 1'b1;
            pend_d_r <= src_data;
        end
    end

    sync2 u_ack_sync (.clk(src_clk), .rst(rst), .d(ack_t_r), .q(ack_s));
    sync2 u_req_sync (.clk(dst_clk), .rst(rst), .d(req_t_r), .q(req_s));

    ////////////////////////////////////////////////////////////////////////////////
    // Destination: capture on toggle change, answer with the ack toggle
    always_ff @(posedge dst_clk or posedge rst) begin
        if (rst) begin
            req_d_r   <= 1'b0;
            ack_t_r   <= 1'b0;
            dst_valid <= 1'b0;
            dst_data  <= '0;
        end else begin
            req_d_r   <= req_s;
            ack_t_r   <= req_s;
            dst_valid <= req_s ^ req_d_r;
            if (req_s ^ req_d_r) begin
                dst_data <= hold_r;
            end
        end
    end
endmodule

// File: rtl/keypad_regs.sv
// Keypad interrupt mask and key-code registers behind a serial register port
`timescale 1ns/10ps

//
// Behaviour
// - Masked source never drives interrupt, raw still records
// - Mask bit 3 blocks event-lost, resets 0
// - Mask bit 2 blocks event-present, resets 0
// - Mask bit 1 blocks key-lost, resets 1
// - Mask bit 0 blocks scan-change, resets 1
// - Four read-only key-code registers report simultaneous keys
// - Bit 7 flags another key in next register
// - Reading all four codes clears scan and lost
// - First code reads 0x7F with no key
// - Bits 6:4 hold row, reset 7
// - Bits 3:0 hold column, reset 0xF
// - Changed scan raises scan-change raw flag
// - Clear bit 0 clears scan and key-lost
// - Key-lost on uncleared change or over four keys
module keypad_regs #(
    parameter logic [6:0] DEV_ADDR = keypad_pkg::DEV_ADDR_DEFAULT
) (
    // System clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // Serial register port pins
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    // Scan engine report, scan clock domain
    input  wire logic        SCAN_CLK,
    input  wire logic        SCAN_DONE,
    input  wire logic        SCAN_CHANGED,
    input  wire logic [2:0]  SCAN_NKEYS,
    input  wire logic [11:0] SCAN_ROWS,
    input  wire logic [15:0] SCAN_COLS,
    // Event buffer sources, system clock domain
    input  wire logic        EVENT_RAW,
    input  wire logic        EVENT_LOST_RAW,
    output logic             EVENT_CLEAR,
    // Interrupt request, active low
    output logic             IRQ_N
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam int RPT_W = 32;

    logic                          scl_s;
    logic                          sda_s;
    logic                          scl_d_r;
    logic                          sda_d_r;
    logic                          scl_rise;
    logic                          scl_fall;
    logic                          start_det;
    logic                          stop_det;

    keypad_pkg::bus_state_e        state_r;
    logic [3:0]                    bitcnt_r;
    logic [7:0]                    shift_r;
    logic [7:0]                    tx_r;
    logic [7:0]                    ptr_r;
    logic                          rw_r;
    logic                          mack_r;
    logic                          wr_stb;
    logic [7:0]                    wr_addr;
    logic [7:0]                    wr_data;
    logic                          rd_stb;
    logic [7:0]                    rd_addr;
    logic [7:0]                    rd_data;

    logic                          rpt_valid;
    logic [RPT_W-1:0]              rpt_data;
    logic [2:0]                    nkeys_r;
    logic [11:0]                   rows_r;
    logic [15:0]                   cols_r;
    logic [7:0]                    code [keypad_pkg::KEY_SLOTS];

    logic [keypad_pkg::MASK_WIDTH-1:0] mask_r;
    logic                          scan_change_raw_r;
    logic                          key_lost_raw_r;
    logic [3:0]                    codes_read_r;
    logic                          clear_scan;
    logic                          auto_clear;
    logic [3:0]                    raw_vec;

    ////////////////////////////////////////////////////////////////////////////////
    // Build one key-code byte from the latest report
    function automatic logic [7:0] key_code(input logic [2:0] idx,
                                            input logic [2:0] nkeys,
                                            input logic [2:0] row,
                                            input logic [3:0] col);
        logic [7:0] c;
        c = keypad_pkg::CODE_NO_KEY;
        if (idx < nkeys) begin
            c = {(3'(idx + 3'h1) < nkeys), row, col};
        end
        return c;
    endfunction

    // Register read decode; unmapped offsets read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [3:0] m,
                                            input logic [7:0] c0,
                                            input logic [7:0] c1,
                                            input logic [7:0] c2,
                                            input logic [7:0] c3);
        logic [7:0] r;
        r = keypad_pkg::UNMAPPED_RD;
        case (a)
            keypad_pkg::OFS_MASK:  r = {4'h0, m};
            keypad_pkg::OFS_CODE0: r = c0;
            keypad_pkg::OFS_CODE1: r = c1;
            keypad_pkg::OFS_CODE2: r = c2;
            keypad_pkg::OFS_CODE3: r = c3;
            default:               r = keypad_pkg::UNMAPPED_RD;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; edges are taken from the second stage only
    sync2 u_scl_sync (.clk(CLK_SYS), .rst(SYS_RST), .d(SCL_I), .q(scl_s));
    sync2 u_sda_sync (.clk(CLK_SYS), .rst(SYS_RST), .d(SDA_I), .q(sda_s));

    // Previous synchronised pin levels, reset to the idle-high bus
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Bus conditions: data moving while clock high marks frame edges
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial slave: bits shift in on clock rise, state moves on clock fall
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r  <= keypad_pkg::ST_IDLE;
            bitcnt_r <= 4'h0;
            shift_r  <= 8'h00;
            tx_r     <= 8'h00;
            ptr_r    <= 8'h00;
            rw_r     <= 1'b0;
            mack_r   <= 1'b0;
        end else if (start_det) begin
            state_r  <= keypad_pkg::ST_ADDR;
            bitcnt_r <= 4'h0;
        end else if (stop_det) begin
            state_r  <= keypad_pkg::ST_IDLE;
        end else if (scl_rise) begin
            case (state_r)
                keypad_pkg::ST_ADDR, keypad_pkg::ST_REG, keypad_pkg::ST_WDATA: begin
                    shift_r  <= {shift_r[6:0], sda_s};
                    bitcnt_r <= bitcnt_r + 4'h1;
                end
                keypad_pkg::ST_RDATA: begin
                    bitcnt_r <= bitcnt_r + 4'h1;
                end
                keypad_pkg::ST_RACK: begin
                    mack_r <= ~sda_s;
                end
                default: begin
                    bitcnt_r <= bitcnt_r;
                end
            endcase
        end else if (scl_fall) begin
            case (state_r)
                keypad_pkg::ST_ADDR: begin
                    if (bitcnt_r == 4'h8) begin
                        rw_r    <= shift_r[0];
                        state_r <= (shift_r[7:1] == DEV_ADDR) ? keypad_pkg::ST_ACK_A
                                                              : keypad_pkg::ST_IDLE;
                    end
                end
                keypad_pkg::ST_ACK_A: begin
                    bitcnt_r <= 4'h0;
                    if (rw_r) begin
                        tx_r    <= rd_data;
                        ptr_r   <= ptr_r + 8'h01;
                        state_r <= keypad_pkg::ST_RDATA;
                    end else begin
                        state_r <= keypad_pkg::ST_REG;
                    end
                end
                keypad_pkg::ST_REG: begin
                    if (bitcnt_r == 4'h8) begin
                        ptr_r   <= shift_r;
                        state_r <= keypad_pkg::ST_ACK_R;
                    end
                end
                keypad_pkg::ST_ACK_R, keypad_pkg::ST_ACK_W: begin
                    bitcnt_r <= 4'h0;
                    state_r  <= keypad_pkg::ST_WDATA;
                end
                keypad_pkg::ST_WDATA: begin
                    if (bitcnt_r == 4'h8) begin
                        ptr_r   <= ptr_r + 8'h01;
                        state_r <= keypad_pkg::ST_ACK_W;
                    end
                end
                keypad_pkg::ST_RDATA: begin
                    if (bitcnt_r == 4'h8) begin
                        state_r <= keypad_pkg::ST_RACK;
                    end else begin
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
                keypad_pkg::ST_RACK: begin
                    bitcnt_r <= 4'h0;
                    if (mack_r) begin
                        tx_r    <= rd_data;
                        ptr_r   <= ptr_r + 8'h01;
                        state_r <= keypad_pkg::ST_RDATA;
                    end else begin
                        state_r <= keypad_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= keypad_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Open-drain data pin: pull low for acknowledges and zero read bits
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            SDA_OE <= 1'b0;
        end else begin
            case (state_r)
                keypad_pkg::ST_ACK_A, keypad_pkg::ST_ACK_R, keypad_pkg::ST_ACK_W:
                    SDA_OE <= 1'b1;
                keypad_pkg::ST_RDATA:
                    SDA_OE <= ~tx_r[7];
                default:
                    SDA_OE <= 1'b0;
            endcase
        end
    end
    assign SDA_O = 1'b0;

    // Access strobes: one cycle each, as a byte is committed on the bus
    assign wr_stb  = scl_fall & (state_r == keypad_pkg::ST_WDATA) & (bitcnt_r == 4'h8)
                     & ~start_det & ~stop_det;
    assign wr_addr = ptr_r;
    assign wr_data = shift_r;
    assign rd_stb  = scl_fall & ~start_det & ~stop_det &
                     (((state_r == keypad_pkg::ST_ACK_A) & rw_r) |
                      ((state_r == keypad_pkg::ST_RACK) & mack_r));
    assign rd_addr = ptr_r;
    assign rd_data = reg_read(ptr_r, mask_r, code[0], code[1], code[2], code[3]);

    ////////////////////////////////////////////////////////////////////////////////
    // Scan reports cross from the scan clock by toggle handshake
    scan_xfer #(
        .W (RPT_W)
    ) u_scan_xfer (
        .src_clk   (SCAN_CLK),
        .rst       (SYS_RST),
        .src_valid (SCAN_DONE),
        .src_data  ({SCAN_CHANGED, SCAN_NKEYS, SCAN_ROWS, SCAN_COLS}),
        .dst_clk   (CLK_SYS),
        .dst_valid (rpt_valid),
        .dst_data  (rpt_data)
    );

    // Latest key set; empty after reset so every code reads idle
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            nkeys_r <= 3'h0;
            rows_r  <= {4{keypad_pkg::ROW_RESET}};
            cols_r  <= {4{keypad_pkg::COL_RESET}};
        end else if (rpt_valid) begin
            nkeys_r <= rpt_data[30:28];
            rows_r  <= rpt_data[27:16];
            cols_r  <= rpt_data[15:0];
        end
    end

    always_comb begin
        for (int i = 0; i < keypad_pkg::KEY_SLOTS; i++) begin
            code[i] = key_code(3'(i), nkeys_r, rows_r[3*i +: 3], cols_r[4*i +: 4]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt mask register
    // mask bit 3 reset 0
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            mask_r <= keypad_pkg::MASK_RESET;
        end else if (wr_stb && wr_addr == keypad_pkg::OFS_MASK) begin
            mask_r <= wr_data[keypad_pkg::MASK_WIDTH-1:0];
        end
    end

    assign clear_scan = wr_stb & (wr_addr == keypad_pkg::OFS_CLEAR) &
                        wr_data[keypad_pkg::CLR_SCAN_BIT];

    // Event buffer clear goes out to the buffer logic as a pulse
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            EVENT_CLEAR <= 1'b0;
        end else begin
            EVENT_CLEAR <= wr_stb & (wr_addr == keypad_pkg::OFS_CLEAR) &
                           wr_data[keypad_pkg::CLR_EVT_BIT];
        end
    end

    // track code reads
    // A new report restarts tracking so stale reads never clear a fresh change
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            codes_read_r <= 4'h0;
        end else if (rpt_valid || auto_clear) begin
            codes_read_r <= 4'h0;
        end else if (rd_stb && rd_addr >= keypad_pkg::OFS_CODE0
                            && rd_addr <= keypad_pkg::OFS_CODE3) begin
            codes_read_r[2'(rd_addr - keypad_pkg::OFS_CODE0)] <= 1'b1;
        end
    end
    assign auto_clear = (codes_read_r == 4'hf) & ~rpt_valid;

    // auto clear after reads
    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            scan_change_raw_r <= 1'b0;
        end else if (rpt_valid && rpt_data[31]) begin
            scan_change_raw_r <= 1'b1;
        end else if (clear_scan || auto_clear) begin
            scan_change_raw_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            key_lost_raw_r <= 1'b0;
        end else if (rpt_valid && ((rpt_data[31] && scan_change_raw_r) ||
                                   rpt_data[30:28] > 3'(keypad_pkg::KEY_SLOTS))) begin
            key_lost_raw_r <= 1'b1;
        end else if (clear_scan || auto_clear) begin
            key_lost_raw_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Raw sources in mask bit order
    assign raw_vec[keypad_pkg::MASK_EVT_LOST_BIT] = EVENT_LOST_RAW;
    assign raw_vec[keypad_pkg::MASK_EVT_BIT]      = EVENT_RAW;
    assign raw_vec[keypad_pkg::MASK_KEY_LOST_BIT] = key_lost_raw_r;
    assign raw_vec[keypad_pkg::MASK_SCAN_BIT]     = scan_change_raw_r;

    // any unmasked raw
    // Registered so the pin never glitches while sources and mask change
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            IRQ_N <= 1'b1;
        end else begin
            IRQ_N <= ~|(raw_vec & ~mask_r);
        end
    end

endmodule

// File: testbench/i2c_host.sv
// Behavioural serial host on the register port, open drain with pull-up
`timescale 1ns/10ps
module i2c_host (
    // Pacing clock
    input  wire logic clk,
    // Bus pins
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic host_low = 1'b0;
    initial scl = 1'b1;
    // Pull-up: the line is low while either party pulls it
    assign sda = ~(host_low | sda_oe);
    // Third of a bit, well above the port's minimum of 8 cycles
    task automatic hp;
        repeat (20) @(posedge clk);
    endtask
    // Start or repeated start
    task automatic start;
        host_low <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        host_low <= 1'b1;
        hp();
        scl <= 1'b0;
        hp();
    endtask
    task automatic stop;
        host_low <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        host_low <= 1'b0;
        hp();
    endtask
    // Data moves only mid-low, so the synchronised pins never fake a start or stop
    task automatic bitx(input logic b, output logic r);
        host_low <= ~b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda;
        scl <= 1'b0;
        hp();
    endtask
    // Byte MSB first, then the ninth bit; a high ninth bit releases the line
    task automatic xb(input logic [7:0] d, input logic l, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(l, a);
    endtask
endmodule

// File: testbench/keypad_regs_sva.sv
// Port-level checker for the keypad register slice
`timescale 1ns/10ps
module keypad_regs_sva (
    // Watched ports
    input  wire logic CLK_SYS,
    input  wire logic SYS_RST,
    input  wire logic SCL_I,
    input  wire logic SDA_O,
    input  wire logic SDA_OE,
    input  wire logic SCAN_DONE,
    input  wire logic EVENT_RAW,
    input  wire logic EVENT_LOST_RAW,
    input  wire logic EVENT_CLEAR,
    input  wire logic IRQ_N
);
    logic [7:0] quiet_r;
    logic [1:0] ev_q_r;
    logic       scl_q_r;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // Cycles with no bus edge and no scan report; a report has landed well before 40
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) quiet_r <= 8'h00;
        else if (SCAN_DONE || SCL_I != scl_q_r) quiet_r <= 8'h00;
        else if (quiet_r != 8'hff) quiet_r <= quiet_r + 8'h01;
    end
    // Delayed copies of the pins and sources
    always_ff @(posedge CLK_SYS) begin
        scl_q_r <= SCL_I;
        ev_q_r <= {EVENT_RAW, EVENT_LOST_RAW};
    end
    sda_o_low_a: assert property (SDA_O == 1'b0) else $error("data pin value not low");
    reset_idle_a: assert property (disable iff (1'b0) SYS_RST |-> IRQ_N && !SDA_OE && !EVENT_CLEAR)
        else $error("outputs not idle in reset");
    oe_rise_low_a: assert property ($rose(SDA_OE) |-> !SCL_I) else $error("drive began, clock high");
    oe_fall_low_a: assert property ($fell(SDA_OE) |-> !SCL_I) else $error("drive ended, clock high");
    oe_hold_high_a: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE))
        else $error("data changed while clock high");
    bus_release_a: assert property (quiet_r > 8'h28 |-> !SDA_OE) else $error("idle bus driven");
    irq_cause_a: assert property (quiet_r > 8'h28 && ev_q_r == {EVENT_RAW, EVENT_LOST_RAW}
        && ev_q_r == $past(ev_q_r) |-> $stable(IRQ_N)) else $error("interrupt moved, no cause");
    clear_pulse_a: assert property (EVENT_CLEAR |=> !EVENT_CLEAR) else $error("clear pulse long");
    clear_fall_a: assert property (EVENT_CLEAR |-> !SCL_I) else $error("clear pulse, clock high");
    irq_low_c: cover property ($fell(IRQ_N));
    clear_c: cover property (EVENT_CLEAR);
    ack_c: cover property ($rose(SDA_OE));
endmodule
bind keypad_regs keypad_regs_sva chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SCL_I(SCL_I),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SCAN_DONE(SCAN_DONE), .EVENT_RAW(EVENT_RAW),
    .EVENT_LOST_RAW(EVENT_LOST_RAW), .EVENT_CLEAR(EVENT_CLEAR), .IRQ_N(IRQ_N));

// File: testbench/keypad_regs_tb.sv
// Self-checking bench for the keypad mask and key-code registers
`timescale 1ns/10ps
module keypad_regs_tb;
    logic        clk, sclk, scl, sda, sda_o, sda_oe, ev_clr, irq_n;
    logic        rst, done = 1'b0, chg = 1'b0, ev = 1'b0, evl = 1'b0;
    logic [7:0]  clr_seen = 8'h00;
    logic [2:0]  nk = 3'h0;
    logic [11:0] rows = 12'h000;
    logic [15:0] cols = 16'h0000;
    int          n_errors = 0, check_count = 0, cycles = 0;
    keypad_regs dut (.CLK_SYS(clk), .SYS_RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .SCAN_CLK(sclk), .SCAN_DONE(done), .SCAN_CHANGED(chg), .SCAN_NKEYS(nk),
        .SCAN_ROWS(rows), .SCAN_COLS(cols), .EVENT_RAW(ev), .EVENT_LOST_RAW(evl),
        .EVENT_CLEAR(ev_clr), .IRQ_N(irq_n));
    i2c_host host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    ////////////////////////////////////////////////////////////////////////////////
    // Clocks: the scan clock is offset so the two never line up
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        sclk = 1'b0;
        #1.3;
        forever #3 sclk = ~sclk;
    end
    // Event clear pulses seen, judged once the clear write is done
    always @(posedge clk) if (ev_clr) clr_seen <= clr_seen + 8'h01;
    // Hang guard, about twice the expected run
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 80000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] q;
        logic       a;
        host.start();
        host.xb(8'h88, 1'b1, q, a);
        host.xb(ofs, 1'b1, q, a);
        host.xb(d, 1'b1, q, a);
        chk("write ack", {7'h00, a}, 8'h00);
        host.stop();
    endtask
    // Single-byte read ended by a host NACK
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] q;
        logic       a;
        host.start();
        host.xb(8'h88, 1'b1, q, a);
        host.xb(ofs, 1'b1, q, a);
        host.start();
        host.xb(8'h89, 1'b1, q, a);
        host.xb(8'hff, 1'b1, q, a);
        host.stop();
        chk($sformatf("register %h", ofs), q, exp);
    endtask
    // Interrupt settles within a few cycles; 30 covers the crossing too
    task automatic irq(input logic exp);
        repeat (30) @(posedge clk);
        chk("interrupt", {7'h00, irq_n}, {7'h00, exp});
    endtask
    task automatic scan(input logic c, input logic [2:0] n, input logic [11:0] r, input logic [15:0] k);
        @(posedge sclk);
        done <= 1'b1;
        chg <= c;
        nk <= n;
        rows <= r;
        cols <= k;
        @(posedge sclk);
        done <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(8'h09, 8'h03);
        rd(8'h0b, 8'h7f);
        rd(8'h0a, 8'h00);
        irq(1'b1);
    endtask
    // Two keys, scan source masked at first, then codes read until auto clear
    task automatic t_codes;
        scan(1'b1, 3'h2, 12'h03b, 16'h00bc);
        irq(1'b1);
        wr(8'h09, 8'h00);
        irq(1'b0);
        rd(8'h0b, 8'hbc);
        rd(8'h0c, 8'h7b);
        rd(8'h0d, 8'h7f);
        irq(1'b0);
        rd(8'h0e, 8'h7f);
        irq(1'b1);
    endtask
    // Lost key: change on uncleared scan flag, then too many keys
    task automatic t_lost;
        wr(8'h09, 8'h0d);
        scan(1'b1, 3'h1, 12'h001, 16'h0002);
        irq(1'b1);
        scan(1'b1, 3'h1, 12'h001, 16'h0002);
        irq(1'b0);
        wr(8'h08, 8'h01);
        irq(1'b1);
        scan(1'b0, 3'h5, 12'h000, 16'h0000);
        irq(1'b0);
        wr(8'h08, 8'h01);
        irq(1'b1);
        wr(8'h0b, 8'h55);
        rd(8'h0b, 8'h80);
    endtask
    // Buffer sources under the host's recommended mask settings
    task automatic t_events;
        ev <= 1'b1;
        wr(8'h09, 8'h03);
        irq(1'b0);
        wr(8'h09, 8'h0f);
        irq(1'b1);
        ev <= 1'b0;
        evl <= 1'b1;
        wr(8'h09, 8'h03);
        irq(1'b0);
        wr(8'h09, 8'h0c);
        irq(1'b1);
        evl <= 1'b0;
        wr(8'h08, 8'h02);
        chk("event clear", clr_seen, 8'h01);
        rd(8'h09, 8'h0c);
    endtask
    task automatic end_sim;
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        // Raised at time zero so the asynchronous reset sees an edge
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        t_reset();
        t_codes();
        t_lost();
        t_events();
        end_sim();
    end
endmodule
